// File: logic/mscr_regs.sv
// per-port interrupt address/data, subsystem id and indirect config access registers
`default_nettype none
module mscr_regs
  import mscr_pkg::*;
(
  input  wire logic                    mclk,
  input  wire logic                    rst,
  input  wire mscr_pkg::mscr_cfg_req_t cfg_req,
  output var  mscr_pkg::mscr_cfg_rsp_t cfg_rsp,
  input  wire logic                    lock_open,
  input  wire logic                    msi_enable,
  input  wire logic                    msi_req,
  output var  mscr_pkg::mscr_msi_wr_t  msi_wr
);
  import mscr_pkg::*;

  logic [LO_ADDR_W-1:0]   lo_addr_ff,   nxt_lo_addr;
  logic [DATA_W-1:0]      hi_addr_ff,   nxt_hi_addr;
  logic [PAYLOAD_W-1:0]   payload_ff,   nxt_payload;
  logic [NEXT_LINK_W-1:0] next_link_ff, nxt_next_link;
  logic [DATA_W-1:0]      ident_ff,     nxt_ident;
  logic [SEL_DW_W-1:0]    sel_dw_ff,    nxt_sel_dw;
  logic [SEL_EXT_W-1:0]   sel_ext_ff,   nxt_sel_ext;
  mscr_cfg_rsp_t          rsp_ff,       nxt_rsp;

  logic [11:0]       ind_addr;
  logic [11:0]       tgt_addr;
  logic              via_window;
  logic              self_ptr;
  logic              wr_en;
  logic [DATA_W-1:0] bmask;
  logic [DATA_W-1:0] rd_data;
  logic [DATA_W-1:0] img_lo, img_pay, img_cap, img_sel;

  // indirect target: the selector forms a dword index into config space
  assign ind_addr   = {sel_ext_ff, sel_dw_ff, DW_ALIGN};
  assign via_window = (cfg_req.addr == OFF_WINDOW);
  // pointing the window at the selector or at itself would recurse, so it is cut off
  assign self_ptr   = via_window &&
                      (ind_addr == OFF_SELECTOR || ind_addr == OFF_WINDOW);
  assign tgt_addr   = via_window ? ind_addr : cfg_req.addr;
  assign wr_en      = cfg_req.valid && cfg_req.write && !self_ptr;

  // one byte lane of write mask per enable bit
  for (genvar i = 0; i < BE_W; i++) begin : g_lane
    assign bmask[8*i +: 8] = {8{cfg_req.be[i]}};
  end

  // full-word images; reserved positions are constant zero, never stored
  assign img_lo  = {lo_addr_ff, DW_ALIGN};
  assign img_pay = {ZERO_HALF, payload_ff};
  assign img_cap = {ZERO_HALF, next_link_ff, CAP_CODE};
  assign img_sel = {ZERO_SEL_TOP, sel_ext_ff, sel_dw_ff, DW_ALIGN};

  function automatic logic [DATA_W-1:0] merge(input logic [DATA_W-1:0] old,
                                              input logic [DATA_W-1:0] wd,
                                              input logic [DATA_W-1:0] m);
    merge = (old & ~m) | (wd & m);
  endfunction

  // read multiplexer; unmapped targets read zero
  always_comb begin
    rd_data = ZERO_WORD;
    if (!self_ptr) begin
      case (tgt_addr)
        OFF_LO_ADDR:  rd_data = img_lo;
        OFF_HI_ADDR:  rd_data = hi_addr_ff;
        OFF_PAYLOAD:  rd_data = img_pay;
        OFF_CAP_HDR:  rd_data = img_cap;
        OFF_IDENT:    rd_data = ident_ff;
        OFF_SELECTOR: rd_data = img_sel;
        default:      rd_data = ZERO_WORD;
      endcase
    end
  end

  // next register values; only stored fields are updated, so reserved writes vanish
  always_comb begin
    logic [DATA_W-1:0] m;
    m             = ZERO_WORD;
    nxt_lo_addr   = lo_addr_ff;
    nxt_hi_addr   = hi_addr_ff;
    nxt_payload   = payload_ff;
    nxt_next_link = next_link_ff;
    nxt_ident     = ident_ff;
    nxt_sel_dw    = sel_dw_ff;
    nxt_sel_ext   = sel_ext_ff;
    if (wr_en) begin
      case (tgt_addr)
        OFF_LO_ADDR: begin
          m           = merge(img_lo, cfg_req.wdata, bmask);
          nxt_lo_addr = m[DATA_W-1:LO_ADDR_LSB];
        end
        OFF_HI_ADDR: begin
          nxt_hi_addr = merge(hi_addr_ff, cfg_req.wdata, bmask);
        end
        OFF_PAYLOAD: begin
          m           = merge(img_pay, cfg_req.wdata, bmask);
          nxt_payload = m[PAYLOAD_W-1:0];
        end
        OFF_CAP_HDR: begin
          m = merge(img_cap, cfg_req.wdata, bmask);
          if (lock_open) begin
            nxt_next_link = m[NEXT_LINK_LSB +: NEXT_LINK_W];
          end
        end
        OFF_IDENT: begin
          if (lock_open) begin
            nxt_ident = merge(ident_ff, cfg_req.wdata, bmask);
          end
        end
        OFF_SELECTOR: begin
          m           = merge(img_sel, cfg_req.wdata, bmask);
          nxt_sel_dw  = m[SEL_DW_LSB +: SEL_DW_W];
          nxt_sel_ext = m[SEL_EXT_LSB +: SEL_EXT_W];
        end
        default: m = ZERO_WORD;
      endcase
    end
  end

  // answer one cycle after every request; writes answer with zero data
  always_comb begin
    nxt_rsp       = '0;
    nxt_rsp.valid = cfg_req.valid;
    if (cfg_req.valid && !cfg_req.write) begin
      nxt_rsp.rdata = rd_data;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      lo_addr_ff   <= LO_ADDR_RST;
      hi_addr_ff   <= HI_ADDR_RST;
      payload_ff   <= PAYLOAD_RST;
      next_link_ff <= NEXT_LINK_RST;
      ident_ff     <= IDENT_RST;
      sel_dw_ff    <= SEL_DW_RST;
      sel_ext_ff   <= SEL_EXT_RST;
      rsp_ff       <= '0;
    end else begin
      lo_addr_ff   <= nxt_lo_addr;
      hi_addr_ff   <= nxt_hi_addr;
      payload_ff   <= nxt_payload;
      next_link_ff <= nxt_next_link;
      ident_ff     <= nxt_ident;
      sel_dw_ff    <= nxt_sel_dw;
      sel_ext_ff   <= nxt_sel_ext;
      rsp_ff       <= nxt_rsp;
    end
  end

  assign cfg_rsp = rsp_ff;

  // the write builder registers its own output, keeping msi_wr flop-driven
  mscr_msi_gen u_msi_gen (
    .mclk       (mclk),
    .rst        (rst),
    .msi_req    (msi_req),
    .msi_enable (msi_enable),
    .lo_addr    (lo_addr_ff),
    .hi_addr    (hi_addr_ff),
    .payload    (payload_ff),
    .msi_wr     (msi_wr)
  );

  logic rd_req;
  assign rd_req = cfg_req.valid && !cfg_req.write;

  property p_lo_align;
    @(posedge mclk) disable iff (rst)
    (rd_req && tgt_addr == OFF_LO_ADDR && !self_ptr)
      |=> (cfg_rsp.valid && cfg_rsp.rdata[1:0] == DW_ALIGN);
  endproperty
  a_lo_align: assert property (p_lo_align) else $error("low address bits not zero");

  property p_pay_top;
    @(posedge mclk) disable iff (rst)
    (rd_req && tgt_addr == OFF_PAYLOAD && !self_ptr)
      |=> (cfg_rsp.rdata[31:16] == ZERO_HALF && cfg_rsp.rdata[15:0] == $past(payload_ff));
  endproperty
  a_pay_top: assert property (p_pay_top) else $error("payload read wrong");

  property p_cap_code;
    @(posedge mclk) disable iff (rst)
    (rd_req && tgt_addr == OFF_CAP_HDR && !self_ptr)
      |=> (cfg_rsp.rdata[7:0] == CAP_CODE && cfg_rsp.rdata[31:16] == ZERO_HALF);
  endproperty
  a_cap_code: assert property (p_cap_code) else $error("capability code wrong");

  property p_link_lock;
    @(posedge mclk) disable iff (rst)
    !lock_open |=> $stable(next_link_ff);
  endproperty
  a_link_lock: assert property (p_link_lock) else $error("next link changed while locked");

  property p_ident_lock;
    @(posedge mclk) disable iff (rst)
    !lock_open |=> $stable(ident_ff);
  endproperty
  a_ident_lock: assert property (p_ident_lock) else $error("identifier changed while locked");

  property p_sel_rsvd;
    @(posedge mclk) disable iff (rst)
    (rd_req && cfg_req.addr == OFF_SELECTOR)
      |=> (cfg_rsp.rdata[1:0] == DW_ALIGN && cfg_rsp.rdata[31:12] == ZERO_SEL_TOP);
  endproperty
  a_sel_rsvd: assert property (p_sel_rsvd) else $error("selector reserved bits set");

  property p_self_zero;
    @(posedge mclk) disable iff (rst)
    (rd_req && self_ptr) |=> (cfg_rsp.valid && cfg_rsp.rdata == ZERO_WORD);
  endproperty
  a_self_zero: assert property (p_self_zero) else $error("self-pointed window read not zero");

  property p_self_drop;
    @(posedge mclk) disable iff (rst)
    (cfg_req.valid && cfg_req.write && self_ptr) |=> ($stable(sel_dw_ff) && $stable(sel_ext_ff));
  endproperty
  a_self_drop: assert property (p_self_drop) else $error("self-pointed window write applied");

  property p_window_wr;
    @(posedge mclk) disable iff (rst)
    (cfg_req.valid && cfg_req.write && via_window && ind_addr == OFF_HI_ADDR
     && cfg_req.be == 4'hF)
      |=> (hi_addr_ff == $past(cfg_req.wdata));
  endproperty
  a_window_wr: assert property (p_window_wr) else $error("window write not applied");

endmodule
`default_nettype wire

// File: logic/mscr_pkg.sv
// constants and carrier types for the per-port interrupt and subsystem config registers
`default_nettype none
package mscr_pkg;

  // register byte offsets within the port's configuration space
  localparam logic [11:0] OFF_LO_ADDR  = 12'h0D4;
  localparam logic [11:0] OFF_HI_ADDR  = 12'h0D8;
  localparam logic [11:0] OFF_PAYLOAD  = 12'h0DC;
  localparam logic [11:0] OFF_CAP_HDR  = 12'h0F0;
  localparam logic [11:0] OFF_IDENT    = 12'h0F4;
  localparam logic [11:0] OFF_SELECTOR = 12'h0F8;
  localparam logic [11:0] OFF_WINDOW   = 12'h0FC;

  // field positions and widths
  localparam int LO_ADDR_LSB   = 2;
  localparam int LO_ADDR_W     = 30;
  localparam int PAYLOAD_W     = 16;
  localparam int NEXT_LINK_LSB = 8;
  localparam int NEXT_LINK_W   = 8;
  localparam int SEL_DW_LSB    = 2;
  localparam int SEL_DW_W      = 6;
  localparam int SEL_EXT_LSB   = 8;
  localparam int SEL_EXT_W     = 4;
  localparam int DATA_W        = 32;
  localparam int BE_W          = 4;

  // fixed values and reset values
  localparam logic [7:0]  CAP_CODE      = 8'h0D;
  localparam logic [7:0]  NEXT_LINK_RST = 8'h00;
  localparam logic [29:0] LO_ADDR_RST   = 30'h0;
  localparam logic [31:0] HI_ADDR_RST   = 32'h0;
  localparam logic [15:0] PAYLOAD_RST   = 16'h0;
  localparam logic [31:0] IDENT_RST     = 32'h0;
  localparam logic [5:0]  SEL_DW_RST    = 6'h0;
  localparam logic [3:0]  SEL_EXT_RST   = 4'h0;
  localparam logic [1:0]  DW_ALIGN      = 2'h0;
  localparam logic [15:0] ZERO_HALF     = 16'h0;
  localparam logic [19:0] ZERO_SEL_TOP  = 20'h0;
  localparam logic [31:0] ZERO_WORD     = 32'h0;

  // configuration request as presented by the port's config decoder
  typedef struct packed {
    logic              valid;
    logic              write;
    logic [11:0]       addr;
    logic [BE_W-1:0]   be;
    logic [DATA_W-1:0] wdata;
  } mscr_cfg_req_t;

  // registered answer to a configuration request
  typedef struct packed {
    logic              valid;
    logic [DATA_W-1:0] rdata;
  } mscr_cfg_rsp_t;

  // interrupt memory write handed to the switch core
  typedef struct packed {
    logic              valid;
    logic              upstream;
    logic              wide;
    logic [63:0]       addr;
    logic [DATA_W-1:0] data;
  } mscr_msi_wr_t;

endpackage
`default_nettype wire

// File: logic/mscr_msi_gen.sv
// interrupt memory write builder: address width choice, payload and routing
`default_nettype none
module mscr_msi_gen
  import mscr_pkg::*;
(
  input  wire logic                   mclk,
  input  wire logic                   rst,
  input  wire logic                   msi_req,
  input  wire logic                   msi_enable,
  input  wire logic [LO_ADDR_W-1:0]   lo_addr,
  input  wire logic [DATA_W-1:0]      hi_addr,
  input  wire logic [PAYLOAD_W-1:0]   payload,
  output var  mscr_pkg::mscr_msi_wr_t msi_wr
);
  import mscr_pkg::*;

  mscr_msi_wr_t msi_wr_ff;
  mscr_msi_wr_t nxt_msi_wr;

  // build the write; a request while disabled is simply dropped
  always_comb begin
    nxt_msi_wr          = '0;
    nxt_msi_wr.valid    = msi_req & msi_enable;
    nxt_msi_wr.upstream = 1'b1;
    nxt_msi_wr.data     = {ZERO_HALF, payload};
    if (hi_addr != ZERO_WORD) begin
      nxt_msi_wr.wide = 1'b1;
      nxt_msi_wr.addr = {hi_addr, lo_addr, DW_ALIGN};
    end else begin
      nxt_msi_wr.wide = 1'b0;
      nxt_msi_wr.addr = {ZERO_WORD, lo_addr, DW_ALIGN};
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      msi_wr_ff <= '0;
    end else begin
      msi_wr_ff <= nxt_msi_wr;
    end
  end

  assign msi_wr = msi_wr_ff;

  property p_gen_wide;
    @(posedge mclk) disable iff (rst)
    (msi_req && msi_enable && hi_addr != ZERO_WORD)
      |=> (msi_wr.valid && msi_wr.wide && msi_wr.addr[63:32] == $past(hi_addr));
  endproperty
  a_gen_wide: assert property (p_gen_wide) else $error("wide address not used");

  property p_gen_narrow;
    @(posedge mclk) disable iff (rst)
    (msi_req && msi_enable && hi_addr == ZERO_WORD)
      |=> (msi_wr.valid && !msi_wr.wide && msi_wr.addr[63:32] == ZERO_WORD
           && msi_wr.addr[31:2] == $past(lo_addr));
  endproperty
  a_gen_narrow: assert property (p_gen_narrow) else $error("narrow address wrong");

  property p_gen_gate;
    @(posedge mclk) disable iff (rst)
    !msi_enable |=> !msi_wr.valid;
  endproperty
  a_gen_gate: assert property (p_gen_gate) else $error("write while disabled");

  property p_gen_route;
    @(posedge mclk) disable iff (rst)
    msi_wr.valid |-> (msi_wr.upstream && msi_wr.data[31:16] == ZERO_HALF
                      && msi_wr.data[15:0] == $past(payload));
  endproperty
  a_gen_route: assert property (p_gen_route) else $error("route or data wrong");

endmodule
`default_nettype wire

// File: verification/mscr_host.sv
// host model issuing configuration requests to the port registers
`default_nettype none
module mscr_host
  import mscr_pkg::*;
(
  input  wire logic                    mclk,
  output var  mscr_pkg::mscr_cfg_req_t cfg_req,
  input  wire mscr_pkg::mscr_cfg_rsp_t cfg_rsp
);
  timeunit 1ns;
  timeprecision 1ps;

  // idle at time zero, nothing requested
  initial cfg_req = '0;

  // one request per call; the answer is sampled at the next falling edge
  task automatic xfer(input logic w, input logic [11:0] a, input logic [3:0] be,
                      input logic [31:0] d, output logic [31:0] rd, output logic ok);
    @(negedge mclk);
    cfg_req <= '{1'b1, w, a, be, d};
    @(negedge mclk);
    ok = cfg_rsp.valid;
    rd = cfg_rsp.rdata;
    // released lines show inverted garbage, never the last value
    cfg_req <= '{1'b0, ~w, ~a, ~be, ~d};
  endtask
endmodule
`default_nettype wire

// File: verification/testbench.sv
// self-checking bench for the interrupt, subsystem id and selector registers
`default_nettype none
module testbench;
  import mscr_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;

  logic          mclk;
  logic          rst;
  logic          lock_open;
  logic          msi_enable;
  logic          msi_req;
  mscr_cfg_req_t cfg_req;
  mscr_cfg_rsp_t cfg_rsp;
  mscr_msi_wr_t  msi_wr;
  logic [31:0]   seed = 32'h41;
  logic [31:0]   m [int];
  int            n_fail;
  int            n_checks;
  int            cyc;

  mscr_regs mscr_regs_i (.mclk(mclk), .rst(rst), .cfg_req(cfg_req), .cfg_rsp(cfg_rsp),
    .lock_open(lock_open), .msi_enable(msi_enable), .msi_req(msi_req), .msi_wr(msi_wr));
  mscr_host mscr_host_i (.mclk(mclk), .cfg_req(cfg_req), .cfg_rsp(cfg_rsp));

  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  // writable bits per register; lockable fields only while the lock is open
  function automatic logic [31:0] wm(input logic [11:0] a, input logic lk);
    case (a)
      OFF_LO_ADDR:  return 32'hFFFFFFFC;
      OFF_HI_ADDR:  return 32'hFFFFFFFF;
      OFF_PAYLOAD:  return 32'h0000FFFF;
      OFF_CAP_HDR:  return lk ? 32'h0000FF00 : 32'h00000000;
      OFF_IDENT:    return lk ? 32'hFFFFFFFF : 32'h00000000;
      OFF_SELECTOR: return 32'h00000FFC;
      default:      return 32'h00000000;
    endcase
  endfunction

  // window accesses resolve through the selector; pointing at itself is dead
  function automatic logic [11:0] tgt(input logic [11:0] a);
    return (a == OFF_WINDOW) ? (m[OFF_SELECTOR][11:0] & 12'hFFC) : a;
  endfunction

  function automatic logic dead(input logic [11:0] a);
    return a == OFF_WINDOW && (tgt(a) == OFF_SELECTOR || tgt(a) == OFF_WINDOW);
  endfunction

  function automatic void mwr(input logic [11:0] a, input logic [3:0] be, input logic [31:0] d);
    logic [11:0] t;
    logic [31:0] k;
    t = tgt(a);
    k = wm(t, lock_open) & {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
    if (!dead(a) && k != 32'h0) m[t] = (m[t] & ~k) | (d & k);
  endfunction

  function automatic logic [31:0] mrd(input logic [11:0] a);
    logic [11:0] t;
    t = tgt(a);
    if (dead(a) || !m.exists(t)) return 32'h0;
    return (t == OFF_CAP_HDR) ? (m[t] | {24'h0, CAP_CODE}) : m[t];
  endfunction

  task automatic chk(input string nm, input logic [63:0] got, input logic [63:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
    end
  endtask

  // one bus cycle through the host, compared with the model
  task automatic acc(input logic w, input logic [11:0] a, input logic [3:0] be,
                     input logic [31:0] d);
    logic [31:0] rd;
    logic        ok;
    mscr_host_i.xfer(w, a, be, d, rd, ok);
    chk("rsp_valid", {63'h0, ok}, 64'h1);
    if (w) begin
      chk("wr_rdata", {32'h0, rd}, 64'h0);
      mwr(a, be, d);
    end else begin
      chk("rdata", {32'h0, rd}, {32'h0, mrd(a)});
    end
  endtask

  task automatic complete_run();
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  // hang guard, far above the roughly 1240 cycles the sequence needs
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 20000) begin
      n_fail++;
      $display("MISMATCH timeout expected done seen hang");
      complete_run();
    end
  end

  initial begin
    logic [11:0] regs [8];
    logic [31:0] hi;
    logic        en;
    regs = '{OFF_LO_ADDR, OFF_HI_ADDR, OFF_PAYLOAD, OFF_CAP_HDR, OFF_IDENT, OFF_SELECTOR,
             OFF_WINDOW, 12'h0E0};
    for (int i = 0; i < 6; i++) m[regs[i]] = 32'h0;
    rst = 1'b1;
    lock_open = 1'b0;
    msi_enable = 1'b0;
    msi_req = 1'b0;
    repeat (12) @(negedge mclk);
    rst = 1'b0;
    // reset values, unmapped place and window at offset zero
    for (int i = 0; i < 8; i++) acc(1'b0, regs[i], 4'hF, 32'h0);
    // random writes with random lanes and lock, each read back
    for (int i = 0; i < 60; i++) begin
      lock_open = 1'(rnd() >> 31);
      acc(1'b1, regs[rnd() % 8], 4'(rnd()), rnd());
      for (int j = 0; j < 8; j++) acc(1'b0, regs[j], 4'hF, 32'h0);
    end
    // window aimed at every register, itself and the selector included
    lock_open = 1'b1;
    for (int i = 0; i < 8; i++) begin
      acc(1'b1, OFF_SELECTOR, 4'hF, {20'h0, regs[i]});
      // full lanes once, so a whole-word write lands through the window
      acc(1'b1, OFF_WINDOW, (i == 1) ? 4'hF : 4'(rnd()), rnd());
      acc(1'b0, OFF_WINDOW, 4'hF, 32'h0);
      acc(1'b0, regs[i], 4'hF, 32'h0);
    end
    // interrupt writes, narrow and wide, one with the enable off
    for (int i = 0; i < 8; i++) begin
      hi = (i % 2 == 1) ? rnd() : 32'h0;
      en = (i != 3);
      acc(1'b1, OFF_HI_ADDR, 4'hF, hi);
      acc(1'b1, OFF_LO_ADDR, 4'hF, rnd());
      acc(1'b1, OFF_PAYLOAD, 4'hF, rnd());
      @(negedge mclk);
      msi_enable = en;
      msi_req = 1'b1;
      @(negedge mclk);
      msi_req = 1'b0;
      chk("msi_valid", {63'h0, msi_wr.valid}, {63'h0, en});
      if (en) begin
        chk("msi_up", {63'h0, msi_wr.upstream}, 64'h1);
        chk("msi_wide", {63'h0, msi_wr.wide}, {63'h0, hi != 32'h0});
        chk("msi_addr", msi_wr.addr, {m[OFF_HI_ADDR], m[OFF_LO_ADDR]});
        chk("msi_data", {32'h0, msi_wr.data}, {48'h0, m[OFF_PAYLOAD][15:0]});
      end
    end
    complete_run();
  end
endmodule
`default_nettype wire
